// *** hdl/loop_status_pkg.sv ***
// Constants for the loop status and reference event readback bank
package loop_status_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          NUM_REFS        = 4;
  localparam int          TW_W            = 30;
  localparam int          TUB_W           = 12;
  localparam logic [15:0] OFS_IO_UPDATE   = 16'h0005;
  localparam logic [7:0]  IO_UPDATE_VALUE = 8'h01;
  localparam logic [15:0] OFS_CLEAR_EVENTS = 16'h0A03;
  localparam int          CLEAR_ALL_BIT   = 1;
  localparam logic [15:0] OFS_EVENT_MASK  = 16'h0A10;
  localparam logic [15:0] OFS_EVENT_CLR_AB = 16'h0A11;
  localparam logic [15:0] OFS_EVENT_CLR_CD = 16'h0A12;
  localparam logic [15:0] OFS_EVENTS_AB   = 16'h0D06;
  localparam logic [15:0] OFS_EVENTS_CD   = 16'h0D07;
  localparam logic [15:0] OFS_LOOP_STATE  = 16'h0D08;
  localparam logic [15:0] OFS_LOOP_EXT    = 16'h0D09;
  localparam logic [15:0] OFS_RESERVED    = 16'h0D0A;
  localparam logic [15:0] OFS_INPUT_AB    = 16'h0D0B;
  localparam logic [15:0] OFS_INPUT_CD    = 16'h0D0C;
  localparam logic [15:0] OFS_TW_B0       = 16'h0D0D;
  localparam logic [15:0] OFS_TW_B1       = 16'h0D0E;
  localparam logic [15:0] OFS_TW_B2       = 16'h0D0F;
  localparam logic [15:0] OFS_TW_B3       = 16'h0D10;
  localparam logic [15:0] OFS_PTUB_LO     = 16'h0D11;
  localparam logic [15:0] OFS_PTUB_HI     = 16'h0D12;
  localparam logic [15:0] OFS_FTUB_LO     = 16'h0D13;
  localparam logic [15:0] OFS_FTUB_HI     = 16'h0D14;
  localparam int          EV_FAULT_BIT    = 0;
  localparam int          EV_CLEARED_BIT  = 1;
  localparam int          EV_VALID_BIT    = 2;
  localparam int          ST_SLOW_BIT     = 0;
  localparam int          ST_FAST_BIT     = 1;
  localparam int          ST_FAULT_BIT    = 2;
  localparam int          ST_VALID_BIT    = 3;
  localparam int          LS_FREERUN_BIT  = 0;
  localparam int          LS_ACTIVE_BIT   = 1;
  localparam int          LS_HOLDOVER_BIT = 2;
  localparam int          LS_SWITCH_BIT   = 3;
  localparam int          LS_PLOCK_BIT    = 4;
  localparam int          LS_FLOCK_BIT    = 5;
  localparam int          LS_SLEW_BIT     = 6;
  localparam int          LX_HIST_BIT     = 4;
  localparam int          LX_CLAMP_BIT    = 5;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
endpackage

// *** hdl/loop_status_bank.sv ***
// Event flags and snapshot status readback bank of the digital loop
// Behaviour
// - Event byte 0x0D06: input 0 flags in bits 2..0, input 1 in 6..4.
// - Event byte 0x0D07: input 2 flags in bits 2..0, input 3 in 6..4.
// - Fault-cleared on recovery, faulted on fault, validated on validation.
// - Loop byte bits 0..3: open-loop, closed-loop, holdover, switchover.
// - Loop byte bit 4 phase lock, bit 5 frequency lock.
// - Loop byte bit 6 set while phase offset is slew limited.
// - Byte 0x0D09 bit 5 shows tuning word clamp; bits 7:6 read zero.
// - Byte 0x0D09 bit 4 shows enough history for holdover.
// - Byte 0x0D09 bits 3:2 hold active reference priority.
// - Byte 0x0D09 bits 1:0 hold active reference index.
// - Loop and input status refresh only when 0x01 written to 0x0005.
// - Input status valid bits: bit 3 input 0, bit 7 input 1.
// - Input status not-valid bits: bit 2 input 0, bit 6 input 1.
// - Fast and slow bits: input 0 bits 1,0; input 1 bits 5,4.
// - Byte 0x0D0C repeats layout for inputs 2 (low) and 3 (high).
// - Bytes 0x0D0D..0x0D10 read the 30-bit tuning word, low first.
// - Bytes 0x0D11/0x0D12 read 12-bit phase lock level, low first.
// - Bytes 0x0D13/0x0D14 read 12-bit frequency lock level, low first.
// - Unmasked events set flags that hold until cleared or reset.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
module loop_status_bank #(
  parameter int NUM_REFS = loop_status_pkg::NUM_REFS
) (
  input  wire logic        I_CLK,          // System clock, 50 MHz
  input  wire logic        I_RESET,        // Async reset, active high
  input  wire logic [15:0] I_ADDR,         // Register address
  input  wire logic [7:0]  I_WDATA,        // Write data
  input  wire logic        I_WR,           // Write strobe
  input  wire logic        I_RD,           // Read strobe
  output logic      [7:0]  O_RDATA,        // Read data, cycle after strobe
  input  wire logic [3:0]  I_REF_VALID,    // Per-input valid for use
  input  wire logic [3:0]  I_REF_FAST,     // Per-input frequency too high
  input  wire logic [3:0]  I_REF_SLOW,     // Per-input frequency too low
  input  wire logic        I_FREERUN,      // Loop open
  input  wire logic        I_ACTIVE,       // Loop closed
  input  wire logic        I_HOLDOVER,     // Loop in holdover
  input  wire logic        I_SWITCHING,    // Switchover in progress
  input  wire logic        I_PHASE_LOCK,   // Phase lock achieved
  input  wire logic        I_FREQ_LOCK,    // Frequency lock achieved
  input  wire logic        I_SLEW_LIMIT,   // Offset slew limited
  input  wire logic        I_CLAMPED,      // Tuning word clamped
  input  wire logic        I_HIST_AVAIL,   // History ready for holdover
  input  wire logic [1:0]  I_ACT_PRIO,     // Active reference priority
  input  wire logic [1:0]  I_ACT_INDEX,    // Active reference index
  input  wire logic [29:0] I_TUNING_WORD,  // Current tuning word
  input  wire logic [11:0] I_PHASE_TUB,    // Phase lock detector level
  input  wire logic [11:0] I_FREQ_TUB,     // Freq lock detector level
  output logic      [7:0]  O_EVENTS_AB,    // Event flags inputs 0,1
  output logic      [7:0]  O_EVENTS_CD     // Event flags inputs 2,3
);

  // ******************************************************************
  // Parameter check
  // ******************************************************************
  if (NUM_REFS != 4)
  begin : g_bad_refs
    $error("loop_status_bank serves exactly four inputs");
  end

  // ******************************************************************
  // Bus decode
  // ******************************************************************
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  logic        io_update;
  logic        clear_all;
  logic [11:0] ev_mask;
  logic [11:0] ev_clear;

  assign io_update = I_WR && hit(I_ADDR, loop_status_pkg::OFS_IO_UPDATE)
                     && (I_WDATA == loop_status_pkg::IO_UPDATE_VALUE);
  assign clear_all = I_WR && hit(I_ADDR, loop_status_pkg::OFS_CLEAR_EVENTS)
                     && I_WDATA[loop_status_pkg::CLEAR_ALL_BIT];

  // Clear strobes: write one to a bit clears the matching flag
  always_comb
  begin
    ev_clear = 12'h000;
    if (I_WR && hit(I_ADDR, loop_status_pkg::OFS_EVENT_CLR_AB))
    begin
      ev_clear[5:0] = {I_WDATA[6:4], I_WDATA[2:0]};
    end
    if (I_WR && hit(I_ADDR, loop_status_pkg::OFS_EVENT_CLR_CD))
    begin
      ev_clear[11:6] = {I_WDATA[6:4], I_WDATA[2:0]};
    end
  end

  // Mask byte: one mask bit per input, low nibble
  logic [3:0] mask_reg;
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      mask_reg <= 4'h0;
    else if (I_WR && hit(I_ADDR, loop_status_pkg::OFS_EVENT_MASK))
      mask_reg <= I_WDATA[3:0];
  end

  // ******************************************************************
  // Reference events
  // ******************************************************************
  logic [3:0]  prev_valid;
  logic        prev_init;
  logic [11:0] ev_set;
  logic [11:0] ev_flags;

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      prev_valid <= 4'h0;
      prev_init  <= 1'b0;
    end
    else
    begin
      prev_valid <= I_REF_VALID;
      prev_init  <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ev
      logic rise;
      logic fall;
      assign rise = prev_init && I_REF_VALID[g] && !prev_valid[g];
      assign fall = prev_init && !I_REF_VALID[g] && prev_valid[g];
      // Validation raises the fault-cleared and validated flags; an earlier fault flag stays set
      assign ev_set[3*g+loop_status_pkg::EV_FAULT_BIT]   =
        fall && !mask_reg[g];
      assign ev_set[3*g+loop_status_pkg::EV_CLEARED_BIT] =
        rise && !mask_reg[g];
      assign ev_set[3*g+loop_status_pkg::EV_VALID_BIT]   =
        rise && !mask_reg[g];
    end
  endgenerate

  // Set wins over a clear in the same cycle
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      ev_flags <= 12'h000;
    else if (clear_all)
      ev_flags <= ev_set;
    else
      ev_flags <= (ev_flags & ~ev_clear) | ev_set;
  end

  assign O_EVENTS_AB = {1'b0, ev_flags[5:3], 1'b0, ev_flags[2:0]};
  assign O_EVENTS_CD = {1'b0, ev_flags[11:9], 1'b0, ev_flags[8:6]};

  // Each flag holds until a clear names it
  for (genvar b = 0; b < 3*NUM_REFS; b++)
  begin : g_sticky
    chk_flag_sticky: assert property (
      @(posedge I_CLK) disable iff (I_RESET)
      (ev_flags[b] && !clear_all && !ev_clear[b]) |=> ev_flags[b])
      else $error("event flag dropped without clear");
  end

  // Per-input event raising and masking
  for (genvar n = 0; n < NUM_REFS; n++)
  begin : g_ev_chk
    chk_fault_event: assert property (
      @(posedge I_CLK) disable iff (I_RESET)
      (prev_init && $fell(I_REF_VALID[n]) && !mask_reg[n])
        |=> ev_flags[3*n+loop_status_pkg::EV_FAULT_BIT])
      else $error("fault event not raised");
    chk_valid_event: assert property (
      @(posedge I_CLK) disable iff (I_RESET)
      (prev_init && $rose(I_REF_VALID[n]) && !mask_reg[n])
        |=> ev_flags[3*n+loop_status_pkg::EV_VALID_BIT]
          && ev_flags[3*n+loop_status_pkg::EV_CLEARED_BIT])
      else $error("validation events not raised");
    chk_masked_event: assert property (
      @(posedge I_CLK) disable iff (I_RESET)
      (mask_reg[n] && !ev_flags[3*n+loop_status_pkg::EV_FAULT_BIT])
        |=> !ev_flags[3*n+loop_status_pkg::EV_FAULT_BIT])
      else $error("masked input raised an event");
  end

  chk_clear_all: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    (clear_all && $stable(I_REF_VALID)) |=> ev_flags == 12'h000)
    else $error("clear all left a flag set");
  chk_clear_one: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    (ev_clear[0] && $stable(I_REF_VALID[0])) |=> !O_EVENTS_AB[0])
    else $error("cleared flag still set");

  // ******************************************************************
  // Status snapshot
  // ******************************************************************
  logic [7:0] loop_state;
  logic [7:0] loop_ext;
  logic [7:0] input_ab;
  logic [7:0] input_cd;

  function automatic logic [3:0] ref_nib(input logic v, input logic f,
                                         input logic s);
    ref_nib = {v, !v, f, s};
  endfunction

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      loop_state <= loop_status_pkg::RESET_BYTE;
      loop_ext   <= loop_status_pkg::RESET_BYTE;
      input_ab   <= loop_status_pkg::RESET_BYTE;
      input_cd   <= loop_status_pkg::RESET_BYTE;
    end
    else if (io_update)
    begin
      loop_state <= {1'b0, I_SLEW_LIMIT, I_FREQ_LOCK, I_PHASE_LOCK,
                     I_SWITCHING, I_HOLDOVER, I_ACTIVE,
                     I_FREERUN};
      loop_ext   <= {2'b00, I_CLAMPED, I_HIST_AVAIL, I_ACT_PRIO,
                     I_ACT_INDEX};
      input_ab   <= {ref_nib(I_REF_VALID[1], I_REF_FAST[1], I_REF_SLOW[1]),
                     ref_nib(I_REF_VALID[0], I_REF_FAST[0],
                             I_REF_SLOW[0])};
      input_cd   <= {ref_nib(I_REF_VALID[3], I_REF_FAST[3], I_REF_SLOW[3]),
                     ref_nib(I_REF_VALID[2], I_REF_FAST[2],
                             I_REF_SLOW[2])};
    end
  end

  chk_state_take: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    io_update |=>
      loop_state[loop_status_pkg::LS_FREERUN_BIT] == $past(I_FREERUN)
      && loop_state[loop_status_pkg::LS_ACTIVE_BIT] == $past(I_ACTIVE)
      && loop_state[loop_status_pkg::LS_HOLDOVER_BIT] == $past(I_HOLDOVER)
      && loop_state[loop_status_pkg::LS_SWITCH_BIT] == $past(I_SWITCHING)
      && loop_state[loop_status_pkg::LS_PLOCK_BIT] == $past(I_PHASE_LOCK)
      && loop_state[loop_status_pkg::LS_FLOCK_BIT] == $past(I_FREQ_LOCK)
      && loop_state[loop_status_pkg::LS_SLEW_BIT] == $past(I_SLEW_LIMIT)
      && !loop_state[7])
    else $error("loop state snapshot wrong");

  chk_ext_take: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    io_update |=>
      loop_ext[loop_status_pkg::LX_CLAMP_BIT] == $past(I_CLAMPED)
      && loop_ext[loop_status_pkg::LX_HIST_BIT] == $past(I_HIST_AVAIL)
      && loop_ext[3:2] == $past(I_ACT_PRIO)
      && loop_ext[7:6] == 2'b00)
    else $error("extended state snapshot wrong");

  chk_ext_hold: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    !io_update |=> $stable(loop_ext) && $stable(input_cd))
    else $error("status changed without io update");

  // Both status bytes as one word for the per-input checks
  logic [15:0] status_all;
  assign status_all = {input_cd, input_ab};

  for (genvar n = 0; n < NUM_REFS; n++)
  begin : g_status_chk
    logic [3:0] nib;
    assign nib = status_all[4*n +: 4];
    chk_input_take: assert property (
      @(posedge I_CLK) disable iff (I_RESET)
      io_update |=>
        nib[loop_status_pkg::ST_VALID_BIT] == $past(I_REF_VALID[n])
        && nib[loop_status_pkg::ST_FAULT_BIT] == !$past(I_REF_VALID[n])
        && nib[loop_status_pkg::ST_FAST_BIT] == $past(I_REF_FAST[n])
        && nib[loop_status_pkg::ST_SLOW_BIT] == $past(I_REF_SLOW[n]))
      else $error("input status snapshot wrong");
  end

  // ******************************************************************
  // Read mux
  // ******************************************************************
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    case (I_ADDR)
      loop_status_pkg::OFS_EVENTS_AB:  next_rdata = O_EVENTS_AB;
      loop_status_pkg::OFS_EVENTS_CD:  next_rdata = O_EVENTS_CD;
      loop_status_pkg::OFS_LOOP_STATE: next_rdata = loop_state;
      loop_status_pkg::OFS_LOOP_EXT:   next_rdata = loop_ext;
      loop_status_pkg::OFS_INPUT_AB:   next_rdata = input_ab;
      loop_status_pkg::OFS_INPUT_CD:   next_rdata = input_cd;
      loop_status_pkg::OFS_TW_B0:   next_rdata = I_TUNING_WORD[7:0];
      loop_status_pkg::OFS_TW_B1:   next_rdata = I_TUNING_WORD[15:8];
      loop_status_pkg::OFS_TW_B2:   next_rdata = I_TUNING_WORD[23:16];
      loop_status_pkg::OFS_TW_B3:
        next_rdata = {2'b00, I_TUNING_WORD[29:24]};
      loop_status_pkg::OFS_PTUB_LO: next_rdata = I_PHASE_TUB[7:0];
      loop_status_pkg::OFS_PTUB_HI:
        next_rdata = {4'h0, I_PHASE_TUB[11:8]};
      loop_status_pkg::OFS_FTUB_LO: next_rdata = I_FREQ_TUB[7:0];
      loop_status_pkg::OFS_FTUB_HI:
        next_rdata = {4'h0, I_FREQ_TUB[11:8]};
      loop_status_pkg::OFS_EVENT_MASK: next_rdata = {4'h0, mask_reg};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      O_RDATA <= 8'h00;
    else if (I_RD)
      O_RDATA <= next_rdata;
    else
      O_RDATA <= 8'h00;
  end

  chk_tw_low: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_ADDR == loop_status_pkg::OFS_TW_B0)
      |=> O_RDATA == $past(I_TUNING_WORD[7:0]))
    else $error("tuning word low byte wrong");

  chk_tw_mid: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_ADDR == loop_status_pkg::OFS_TW_B2)
      |=> O_RDATA == $past(I_TUNING_WORD[23:16]))
    else $error("tuning word third byte wrong");

  chk_ptub_read: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_ADDR == loop_status_pkg::OFS_PTUB_HI)
      |=> O_RDATA == {4'h0, $past(I_PHASE_TUB[11:8])})
    else $error("phase level high byte wrong");

  chk_ev_read: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_ADDR == loop_status_pkg::OFS_EVENTS_AB)
      |=> O_RDATA[7] == 1'b0 && O_RDATA[3] == 1'b0
        && O_RDATA[6:4] == $past(ev_flags[5:3])
        && O_RDATA[2:0] == $past(ev_flags[2:0]))
    else $error("event byte read wrong");

  chk_ext_read: assert property (
    @(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_ADDR == loop_status_pkg::OFS_LOOP_EXT)
      |=> O_RDATA == {2'b00, $past(loop_ext[5:0])})
    else $error("extended state read wrong");

  // ******************************************************************
  // Checks
  // ******************************************************************
  chk_event_sticky: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $rose(ev_flags[0]) |=> ev_flags[0] || $past(clear_all)
      || $past(ev_clear[0]))
    else $error("event flag dropped without clear");
  chk_fault_set: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (prev_init && $fell(I_REF_VALID[0]) && !mask_reg[0])
      |=> O_EVENTS_AB[0])
    else $error("fault event not raised");
  chk_cleared_set: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (prev_init && $rose(I_REF_VALID[2]) && !mask_reg[2])
      |=> O_EVENTS_CD[1] && O_EVENTS_CD[2])
    else $error("recovery events not raised");
  chk_mask_blocks: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (mask_reg[1] && !O_EVENTS_AB[4] && !$past(I_WR)) |=> !O_EVENTS_AB[4])
    else $error("masked event set");
  chk_snap_hold: assert property (@(posedge I_CLK) disable iff (I_RESET)
    !io_update |=> $stable(loop_state) && $stable(input_ab))
    else $error("status changed without io update");
  chk_snap_take: assert property (@(posedge I_CLK) disable iff (I_RESET)
    io_update |=> loop_state[1] == $past(I_ACTIVE)
      && loop_ext[1:0] == $past(I_ACT_INDEX))
    else $error("status snapshot wrong");
  chk_valid_pair: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $past(io_update) |-> input_ab[3] != input_ab[2])
    else $error("valid and fault bits equal");
  chk_tw_read: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_ADDR == loop_status_pkg::OFS_TW_B3)
      |=> O_RDATA == {2'b00, $past(I_TUNING_WORD[29:24])})
    else $error("tuning word top byte wrong");
  chk_tub_read: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_ADDR == loop_status_pkg::OFS_FTUB_HI)
      |=> O_RDATA[7:4] == 4'h0
        && O_RDATA[3:0] == $past(I_FREQ_TUB[11:8]))
    else $error("frequency level high byte wrong");

endmodule // loop_status_bank

// *** test/loop_status_bank_tb_top.sv ***
// Self-checking bench for the loop status readback bank
`timescale 1ns/10ps
module loop_status_bank_tb_top;
  logic        clk, rst, wr, rd;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, ev_ab, ev_cd;
  logic [3:0]  valid, fast, slow;
  logic [6:0]  loop_in;
  logic        clamp, hist;
  logic [1:0]  prio, index;
  logic [29:0] tword;
  logic [11:0] ptub, ftub;
  int          error_cnt, compares, cycles;

  loop_status_bank dut (.I_CLK(clk), .I_RESET(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_REF_VALID(valid), .I_REF_FAST(fast), .I_REF_SLOW(slow),
    .I_FREERUN(loop_in[0]), .I_ACTIVE(loop_in[1]),
    .I_HOLDOVER(loop_in[2]), .I_SWITCHING(loop_in[3]),
    .I_PHASE_LOCK(loop_in[4]), .I_FREQ_LOCK(loop_in[5]),
    .I_SLEW_LIMIT(loop_in[6]), .I_CLAMPED(clamp), .I_HIST_AVAIL(hist),
    .I_ACT_PRIO(prio), .I_ACT_INDEX(index), .I_TUNING_WORD(tword),
    .I_PHASE_TUB(ptub), .I_FREQ_TUB(ftub), .O_EVENTS_AB(ev_ab),
    .O_EVENTS_CD(ev_cd));

  // ***************************************
  // Clock, reset and timeout
  // ***************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt = error_cnt + 1;
      give_verdict();
    end
  end

  // ***************************************
  // Shared tasks
  // ***************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    compares = compares + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp, $sformatf("read %h", a));
  endtask

  task automatic set_valid(input logic [3:0] v);
    @(posedge clk);
    valid <= v;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [3:0] nib(input int n);
    return {valid[n], ~valid[n], fast[n], slow[n]};
  endfunction

  // ***************************************
  // Scenarios
  // ***************************************
  task automatic test_reset;
    chk(ev_ab, 8'h00, "events ab at reset");
    chk(ev_cd, 8'h00, "events cd at reset");
    rd_reg(16'h0D09, 8'h00);
    rd_reg(16'h0D0B, 8'h00);
    rd_reg(16'h0D06, 8'h00);
    rd_reg(16'h0D08, 8'h00);
    rd_reg(16'h0D0A, 8'h00);
  endtask

  task automatic test_events;
    set_valid(4'hE);
    rd_reg(16'h0D06, 8'h01);
    set_valid(4'hF);
    rd_reg(16'h0D06, 8'h07);
    chk(ev_ab, 8'h07, "events ab output");
    set_valid(4'h7);
    set_valid(4'hF);
    rd_reg(16'h0D07, 8'h70);
    chk(ev_cd, 8'h70, "events cd output");
    wr_reg(16'h0A11, 8'h01);
    rd_reg(16'h0D06, 8'h06);
    wr_reg(16'h0D07, 8'h00);
    rd_reg(16'h0D07, 8'h70);
    wr_reg(16'h0A03, 8'h02);
    rd_reg(16'h0D06, 8'h00);
    rd_reg(16'h0D07, 8'h00);
    wr_reg(16'h0A10, 8'h02);
    rd_reg(16'h0A10, 8'h02);
    set_valid(4'hD);
    rd_reg(16'h0D06, 8'h00);
    wr_reg(16'h0A10, 8'h00);
    set_valid(4'h9);
    rd_reg(16'h0D07, 8'h01);
    set_valid(4'hD);
    rd_reg(16'h0D07, 8'h07);
  endtask

  task automatic test_snapshot(input logic [6:0] ls, input logic c,
      input logic h, input logic [1:0] p, input logic [1:0] x,
      input logic [3:0] f, input logic [3:0] s);
    logic [7:0] old_ls;
    old_ls = 8'h00;
    @(posedge clk);
    loop_in <= ls;
    clamp   <= c;
    hist    <= h;
    prio    <= p;
    index   <= x;
    fast    <= f;
    slow    <= s;
    @(posedge clk);
    wr_reg(16'h0005, 8'h01);
    rd_reg(16'h0D08, {1'b0, ls});
    rd_reg(16'h0D09, {2'b00, c, h, p, x});
    rd_reg(16'h0D0B, {nib(1), nib(0)});
    rd_reg(16'h0D0C, {nib(3), nib(2)});
    old_ls = {1'b0, ls};
    @(posedge clk);
    loop_in <= ~ls;
    wr_reg(16'h0005, 8'h02);
    rd_reg(16'h0D08, old_ls);
    @(posedge clk);
    loop_in <= ls;
  endtask

  task automatic test_live;
    logic [15:0] a [8];
    logic [7:0]  e [8];
    a = '{16'h0D0D, 16'h0D0E, 16'h0D0F, 16'h0D10,
          16'h0D11, 16'h0D12, 16'h0D13, 16'h0D14};
    e = '{8'h34, 8'h12, 8'hCD, 8'h2B, 8'h5C, 8'h0A, 8'hF7, 8'h03};
    @(posedge clk);
    tword <= 30'h2BCD1234;
    ptub  <= 12'hA5C;
    ftub  <= 12'h3F7;
    for (int i = 0; i < 8; i++)
      rd_reg(a[i], e[i]);
  endtask

  task automatic test_midreset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_reset();
  endtask

  // ***************************************
  // Main sequence and verdict
  // ***************************************
  task automatic give_verdict;
    $display("Errors %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    error_cnt = 0;
    compares  = 0;
    cycles    = 0;
    rst = 1'b1;
    {wr, rd, addr, wdata} = '0;
    valid = 4'hF;
    {fast, slow, loop_in, clamp, hist, prio, index} = '0;
    {tword, ptub, ftub} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    test_reset();
    test_events();
    test_snapshot(7'h55, 1'b1, 1'b0, 2'h2, 2'h1, 4'h6, 4'h9);
    test_snapshot(7'h2A, 1'b0, 1'b1, 2'h1, 2'h2, 4'h9, 4'h6);
    test_snapshot(7'h7F, 1'b1, 1'b1, 2'h3, 2'h3, 4'hF, 4'h0);
    test_midreset();
    test_live();
    give_verdict();
  end
endmodule // loop_status_bank_tb_top
